// [inc/rtck_pkg.sv]
// Purpose: Shared constants for the timekeeping support block.
// Assumes: Register bytes are 8 bits wide; the block runs from a 200 MHz clock.
// Notes: The crystal is modelled by a tick input at 32.768 kHz or faster.
package rtck_pkg;
    localparam logic [3:0] ADDR_FLAGS = 4'h0;
    localparam logic [3:0] ADDR_ALM_SEC = 4'h2;
    localparam logic [3:0] ADDR_ALM_MIN = 4'h3;
    localparam logic [3:0] ADDR_ALM_HOUR = 4'h4;
    localparam logic [3:0] ADDR_ALM_DATE = 4'h5;
    localparam logic [3:0] ADDR_IRQ_CTRL = 4'h6;
    localparam logic [3:0] ADDR_WD = 4'h7;
    localparam logic [3:0] ADDR_TRIM = 4'h8;
    // Flags register bit positions.
    localparam int FLG_WDF = 7;
    localparam int FLG_AF = 6;
    localparam int FLG_CAL = 2;
    localparam int FLG_W = 1;
    localparam int FLG_OSC_FAIL_FLAG = 0;
    // Interrupt control bit positions.
    localparam int IRQ_WIE = 7;
    localparam int IRQ_AIE = 6;
    localparam int IRQ_SQUARE_WAVE_ENABLE = 3;
    localparam int IRQ_SQ1 = 1;
    localparam int IRQ_SQ0 = 0;
    // Watchdog and trim fields.
    localparam int WD_STROBE = 7;
    localparam int WD_WLOCK = 6;
    localparam int TRIM_OSC_OFF = 7;
    localparam int TRIM_SIGN = 5;
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [7:0] TRIM_RST = 8'h00;
    localparam logic [7:0] WD_RST = 8'h00;
    localparam logic [7:0] IRQ_RST = 8'h00;
    localparam logic [7:0] ALM_RST = 8'h80;
    // Oscillator divider: 32768 cycles per second.
    localparam logic [14:0] DIV_TOP = 15'h7FFF;
    localparam logic [14:0] DIV_SHORT = 15'h0080;
    localparam logic [14:0] DIV_LONG = 15'h0100;
    localparam int CAL_MINUTES = 64;
    localparam int CLK_MHZ = 200;
    localparam int OSC_CHECK_MS = 5;
    localparam int OSC_CHECK_CYC = OSC_CHECK_MS * 1000 * CLK_MHZ;
    localparam int OSC_START_MS = 1000;
    localparam int OSC_START_CYC = OSC_START_MS * 1000 * CLK_MHZ;
endpackage

// [logic/rtck_core.sv]
// Purpose: Oscillator control, trim, alarm, watchdog and interrupt pin selection.
// Assumes: Host register port is synchronous to clk; crystal and backup inputs are pins.
// Notes: Time of day arrives from the clock counters as BCD inputs.
// Functional notes
// - Trim register bit 7 stops the oscillator; reset value keeps it running.
// - After the stop bit clears, the oscillator is expected within one second.
// - At power-up with oscillator enabled, no activity in 5 ms sets oscillator fail.
// - Oscillator failure requests reload of time to the base time, control kept.
// - Trim magnitude is bits 4..0; bit 5 set adds counts, clear removes.
// - Over 64 minutes, first 2N minutes shorten 128 or lengthen 256 cycles.
// - Calibration test bit toggles the interrupt pin at 512 Hz, taken from the trimmed divider count.
// - Flags writes other than the write-unlock bit itself are accepted only while that bit is set.
// - Alarm compares date, hours, minutes and seconds against the current time.
// - A field with match bit zero is compared; all ones disables the alarm.
// - Alarm match sets alarm flag and, if enabled, raises the interrupt.
// - Reading the flags register clears the alarm, watchdog and oscillator fail flags.
// - Alarm writes are staged while unlocked and applied when unlock clears.
// - Watchdog counts down at 32 Hz from the crystal, halted while stopped.
// - Watchdog loads at power-up and reloads whenever the strobe is written.
// - Watchdog reaching zero sets its flag and, if enabled, the interrupt.
// - Write-lock bit set makes timeout bits 5..0 ignore writes.
// - A zero timeout disables the watchdog.
// - Reading flags clears the watchdog flag and its interrupt.
// - Square wave of 1, 512, 4096 or 32768 Hz, silent on backup power.
// - Select bits 00, 01, 10, 11 give 1, 512, 4096, 32768 Hz.
// - Pin priority is calibration test, then square wave, then interrupts.
module rtck_core (
    input wire logic clk,
    input wire logic rst,
    input wire logic osc_clk_pin,
    input wire logic on_backup_pin,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] now_sec,
    input wire logic [7:0] now_min,
    input wire logic [7:0] now_hour,
    input wire logic [7:0] now_date,
    output logic [7:0] reg_rdata,
    output logic osc_run,
    output logic time_reload,
    output logic int_level,
    output logic int_oe
);
    logic osc_q;
    logic osc_rise;
    logic backup_q;
    rtck_sync u_osc_sync (
        .clk(clk),
        .rst(rst),
        .d(osc_clk_pin),
        .q(osc_q),
        .rise(osc_rise)
    );
    rtck_sync u_bak_sync (
        .clk(clk),
        .rst(rst),
        .d(on_backup_pin),
        .q(backup_q),
        .rise()
    );

    logic [7:0] flags_r;
    logic [7:0] trim_r;
    logic [7:0] wd_r;
    logic [7:0] irq_r;
    logic [7:0] alm_stage_r [0:3];
    logic [7:0] alm_live_r [0:3];
    logic [5:0] wd_cnt_r;
    logic [31:0] por_cnt_r;
    logic por_done_r;
    logic osc_seen_r;
    logic sec_d_r;
    logic wd_pwr_load_r;
    logic [7:0] rdata_r;
    logic reload_r;
    logic pin_r;
    logic oe_r;

    logic sec_pulse;
    logic tick_32hz;
    logic [14:0] div_cnt;
    logic osc_tick;
    // Crystal edges only count while the stop bit is clear.
    assign osc_tick = osc_rise && !trim_r[rtck_pkg::TRIM_OSC_OFF];
    rtck_divider u_div (
        .clk(clk),
        .rst(rst),
        .osc_tick(osc_tick),
        .trim_mag(trim_r[4:0]),
        .trim_sign(trim_r[rtck_pkg::TRIM_SIGN]),
        .sec_pulse(sec_pulse),
        .tick_32hz(tick_32hz),
        .div_cnt(div_cnt)
    );

    wire unlocked = flags_r[rtck_pkg::FLG_W];
    wire wr_flags = reg_wr && (reg_addr == rtck_pkg::ADDR_FLAGS);
    wire rd_flags = reg_rd && (reg_addr == rtck_pkg::ADDR_FLAGS);
    wire wr_wd = reg_wr && (reg_addr == rtck_pkg::ADDR_WD);
    wire wr_trim = reg_wr && (reg_addr == rtck_pkg::ADDR_TRIM);
    wire wr_irq = reg_wr && (reg_addr == rtck_pkg::ADDR_IRQ_CTRL);
    wire wr_alm = reg_wr && (reg_addr >= rtck_pkg::ADDR_ALM_SEC)
                  && (reg_addr <= rtck_pkg::ADDR_ALM_DATE);
    wire [1:0] alm_idx = 2'(reg_addr - rtck_pkg::ADDR_ALM_SEC);
    wire relock = wr_flags && unlocked && !reg_wdata[rtck_pkg::FLG_W];

    // Power-up oscillator check window.
    wire osc_fail_evt = !por_done_r && (por_cnt_r == 32'(rtck_pkg::OSC_CHECK_CYC - 1))
                        && !trim_r[rtck_pkg::TRIM_OSC_OFF] && !osc_seen_r;

    // Alarm compare, each field with its match bit in bit 7.
    logic [3:0] fld_ok;
    wire [7:0] now_fld [0:3];
    assign now_fld[0] = now_sec;
    assign now_fld[1] = now_min;
    assign now_fld[2] = now_hour;
    assign now_fld[3] = now_date;
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_alm
            assign fld_ok[g] = alm_live_r[g][7] ||
                               (alm_live_r[g][6:0] == now_fld[g][6:0]);
        end
    endgenerate
    wire alm_off = &{alm_live_r[0][7], alm_live_r[1][7], alm_live_r[2][7], alm_live_r[3][7]};
    wire alarm_evt = sec_d_r && !alm_off && (&fld_ok);

    wire wd_run = (wd_r[5:0] != 6'h00);
    wire wd_evt = wd_run && tick_32hz && (wd_cnt_r == 6'h01);
    wire wd_load = wd_pwr_load_r || (wr_wd && reg_wdata[rtck_pkg::WD_STROBE]);
    // A strobe written together with an unlocked value starts from that new value.
    wire [5:0] wd_load_val = (wr_wd && !reg_wdata[rtck_pkg::WD_WLOCK]) ? reg_wdata[5:0]
                             : wd_r[5:0];

    // Flags next value: read clears, hardware sets win over clears.
    logic [7:0] flags_nxt;
    always_comb begin
        flags_nxt = flags_r;
        if (rd_flags) begin
            flags_nxt[rtck_pkg::FLG_WDF] = 1'b0;
            flags_nxt[rtck_pkg::FLG_AF] = 1'b0;
            flags_nxt[rtck_pkg::FLG_OSC_FAIL_FLAG] = 1'b0;
        end
        if (wr_flags && unlocked) begin
            flags_nxt[rtck_pkg::FLG_CAL] = reg_wdata[rtck_pkg::FLG_CAL];
            flags_nxt[rtck_pkg::FLG_OSC_FAIL_FLAG] = reg_wdata[rtck_pkg::FLG_OSC_FAIL_FLAG];
        end
        if (wr_flags) begin
            flags_nxt[rtck_pkg::FLG_W] = reg_wdata[rtck_pkg::FLG_W];
        end
        if (osc_fail_evt) begin
            flags_nxt[rtck_pkg::FLG_OSC_FAIL_FLAG] = 1'b1;
        end
        if (alarm_evt) begin
            flags_nxt[rtck_pkg::FLG_AF] = 1'b1;
        end
        if (wd_evt) begin
            flags_nxt[rtck_pkg::FLG_WDF] = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            flags_r <= rtck_pkg::FLAGS_RST;
            trim_r <= rtck_pkg::TRIM_RST;
            wd_r <= rtck_pkg::WD_RST;
            irq_r <= rtck_pkg::IRQ_RST;
            por_cnt_r <= 32'h00000000;
            por_done_r <= 1'b0;
            osc_seen_r <= 1'b0;
            sec_d_r <= 1'b0;
            wd_pwr_load_r <= 1'b1;
            reload_r <= 1'b0;
        end else begin
            flags_r <= flags_nxt;
            sec_d_r <= sec_pulse;
            wd_pwr_load_r <= 1'b0;
            reload_r <= osc_fail_evt;
            if (!por_done_r) begin
                por_cnt_r <= por_cnt_r + 32'h00000001;
                por_done_r <= osc_fail_evt || osc_seen_r
                              || (por_cnt_r == 32'(rtck_pkg::OSC_CHECK_CYC - 1));
            end
            if (osc_rise) begin
                osc_seen_r <= 1'b1;
            end
            if (wr_trim) begin
                trim_r <= reg_wdata;
            end
            if (wr_irq) begin
                irq_r <= reg_wdata;
            end
            if (wr_wd) begin
                wd_r[rtck_pkg::WD_WLOCK] <= reg_wdata[rtck_pkg::WD_WLOCK];
                if (!reg_wdata[rtck_pkg::WD_WLOCK]) begin
                    wd_r[5:0] <= reg_wdata[5:0];
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wd_cnt_r <= 6'h00;
        end else if (wd_load) begin
            wd_cnt_r <= wd_load_val;
        end else if (wd_run && tick_32hz && wd_cnt_r != 6'h00) begin
            wd_cnt_r <= wd_cnt_r - 6'h01;
        end
    end

    // Alarm values are staged while unlocked and go live on relock.
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < 4; i++) begin
                alm_stage_r[i] <= rtck_pkg::ALM_RST;
                alm_live_r[i] <= rtck_pkg::ALM_RST;
            end
        end else begin
            if (wr_alm && unlocked) begin
                alm_stage_r[alm_idx] <= reg_wdata;
            end
            if (relock) begin
                for (int i = 0; i < 4; i++) begin
                    alm_live_r[i] <= alm_stage_r[i];
                end
            end
        end
    end

    // Read mux.
    logic [7:0] rd_mux;
    always_comb begin
        case (reg_addr)
            rtck_pkg::ADDR_FLAGS: rd_mux = flags_r;
            rtck_pkg::ADDR_IRQ_CTRL: rd_mux = irq_r;
            rtck_pkg::ADDR_WD: rd_mux = {2'b00, wd_r[5:0]};
            rtck_pkg::ADDR_TRIM: rd_mux = trim_r;
            rtck_pkg::ADDR_ALM_SEC: rd_mux = alm_stage_r[0];
            rtck_pkg::ADDR_ALM_MIN: rd_mux = alm_stage_r[1];
            rtck_pkg::ADDR_ALM_HOUR: rd_mux = alm_stage_r[2];
            rtck_pkg::ADDR_ALM_DATE: rd_mux = alm_stage_r[3];
            default: rd_mux = 8'h00;
        endcase
    end

    // Interrupt pin source selection.
    logic sq_wave;
    always_comb begin
        case ({irq_r[rtck_pkg::IRQ_SQ1], irq_r[rtck_pkg::IRQ_SQ0]})
            2'b00: sq_wave = div_cnt[14];
            2'b01: sq_wave = div_cnt[5];
            2'b10: sq_wave = div_cnt[2];
            default: sq_wave = osc_q;
        endcase
    end
    wire cal_wave = div_cnt[5];
    wire irq_any = (flags_r[rtck_pkg::FLG_AF] && irq_r[rtck_pkg::IRQ_AIE])
                   || (flags_r[rtck_pkg::FLG_WDF] && irq_r[rtck_pkg::IRQ_WIE]);
    wire pin_nxt = flags_r[rtck_pkg::FLG_CAL] ? cal_wave :
                   irq_r[rtck_pkg::IRQ_SQUARE_WAVE_ENABLE] ? sq_wave : irq_any;
    wire oe_nxt = !backup_q && (flags_r[rtck_pkg::FLG_CAL] || irq_r[rtck_pkg::IRQ_SQUARE_WAVE_ENABLE]
                  || irq_any);

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_r <= 8'h00;
            pin_r <= 1'b0;
            oe_r <= 1'b0;
        end else begin
            rdata_r <= reg_rd ? rd_mux : 8'h00;
            pin_r <= pin_nxt;
            oe_r <= oe_nxt;
        end
    end

    logic run_r;
    always_ff @(posedge clk) begin
        if (rst) begin
            run_r <= 1'b0;
        end else begin
            run_r <= !trim_r[rtck_pkg::TRIM_OSC_OFF];
        end
    end

    assign reg_rdata = rdata_r;
    assign osc_run = run_r;
    assign time_reload = reload_r;
    assign int_level = pin_r;
    assign int_oe = oe_r;
endmodule

// [logic/rtck_divider.sv]
// Purpose: Crystal divider with trim and square wave taps.
// Assumes: osc_tick pulses once per crystal cycle.
// Notes: Second length is adjusted in the first 2N minutes of each 64-minute cycle.
module rtck_divider (
    input wire logic clk,
    input wire logic rst,
    input wire logic osc_tick,
    input wire logic [4:0] trim_mag,
    input wire logic trim_sign,
    output logic sec_pulse,
    output logic tick_32hz,
    output logic [14:0] div_cnt
);
    logic [14:0] cnt_r;
    logic [5:0] sec_in_min_r;
    logic [5:0] minute_r;
    logic adjust;
    logic [14:0] sec_top;
    logic sec_end;
    logic [14:0] cnt_inc;
    // Adjust the first second of each minute within the first 2N minutes.
    assign adjust = (sec_in_min_r == 6'h00) && ({1'b0, minute_r} < {1'b0, trim_mag, 1'b0});
    assign sec_top = !adjust ? rtck_pkg::DIV_TOP :
                     trim_sign ? rtck_pkg::DIV_TOP - rtck_pkg::DIV_SHORT :
                     rtck_pkg::DIV_TOP;
    assign cnt_inc = cnt_r + 15'h0001;
    assign sec_end = osc_tick && (cnt_r == sec_top);
    logic [8:0] ext_r;
    logic ext_active;
    // Negative trim holds the count for 256 extra cycles.
    assign ext_active = adjust && !trim_sign && (cnt_r == rtck_pkg::DIV_TOP)
                        && (ext_r != rtck_pkg::DIV_LONG[8:0]);
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= 15'h0000;
            ext_r <= 9'h000;
            sec_in_min_r <= 6'h00;
            minute_r <= 6'h00;
        end else if (osc_tick) begin
            if (ext_active) begin
                ext_r <= ext_r + 9'h001;
            end else if (cnt_r == sec_top) begin
                cnt_r <= 15'h0000;
                ext_r <= 9'h000;
                sec_in_min_r <= (sec_in_min_r == 6'h3B) ? 6'h00 : sec_in_min_r + 6'h01;
                if (sec_in_min_r == 6'h3B) begin
                    minute_r <= minute_r + 6'h01;
                end
            end else begin
                cnt_r <= cnt_inc;
            end
        end
    end
    assign sec_pulse = sec_end && !ext_active;
    assign tick_32hz = osc_tick && !ext_active && (cnt_r[9:0] == 10'h3FF);
    assign div_cnt = cnt_r;
endmodule

// [logic/rtck_sync.sv]
// Purpose: Two flip-flop synchroniser with rising edge pulse.
// Assumes: Input is asynchronous to clk.
// Notes: The second and third stages feed the edge detector.
module rtck_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic d,
    output logic q,
    output logic rise
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end
    assign q = s2_r;
    assign rise = s2_r & ~s3_r;
endmodule

// [tb/rtc_osc_cal_alarm_watchdog_test.sv]
// Purpose: Self-checking bench of the timekeeping core.
// Assumes: Crystal runs at six clock cycles a period.
// Notes: Expected values come from the small model below.
module rtc_osc_cal_alarm_watchdog_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WIN = 1536;
    logic clk, rst, osc_clk_pin, on_backup_pin, reg_wr, reg_rd;
    logic osc_run, time_reload, int_level, int_oe;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, now_sec, now_min, now_hour, now_date, rd_val;
    int n_mismatch = 0;
    int checked = 0;
    int m_wd = 0;
    int m_trim = 0;
    int hp[4] = '{98304, 192, 24, 3};
    bit hit;
    rtck_core rtck_core_i (.clk, .rst, .osc_clk_pin, .on_backup_pin, .reg_wr, .reg_rd,
        .reg_addr, .reg_wdata, .now_sec, .now_min, .now_hour, .now_date, .reg_rdata,
        .osc_run, .time_reload, .int_level, .int_oe);
    rtck_xtal_model rtck_xtal_model_i (.clk(clk), .run(osc_run), .osc(osc_clk_pin));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic report_and_stop();
        $display("Comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
        checked++;
        if (exp !== got) begin
            n_mismatch++;
            $display("FAIL %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic wr(logic [3:0] a, logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [3:0] a);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask
    // Counts pin level changes over a window and compares with the tap rate.
    task automatic sq_chk(int idx);
        int n;
        int e;
        logic last;
        n = 0;
        e = WIN / hp[idx];
        #1;
        last = int_level;
        repeat (WIN) begin
            @(posedge clk);
            #1;
            if (int_level !== last) n++;
            last = int_level;
        end
        checked++;
        if (n < e - 2 || n > e + 2) begin
            n_mismatch++;
            $display("FAIL square_edges expected %0d seen %0d", e, n);
        end
    endtask
    task automatic wait_int(int lim);
        hit = 1'b0;
        repeat (lim) begin
            @(posedge clk);
            #1;
            if (int_oe === 1'b1) begin
                hit = 1'b1;
                break;
            end
        end
    endtask
    function automatic logic [7:0] bcd(int hi);
        return 8'(($urandom % hi) * 16 + $urandom % 10);
    endfunction
    initial begin
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        on_backup_pin = 1'b0;
        void'($urandom(62334));
        now_sec = bcd(6);
        now_min = bcd(6);
        now_hour = bcd(2);
        now_date = bcd(3);
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        rd(rtck_pkg::ADDR_TRIM);
        cmp("trim", rtck_pkg::TRIM_RST, rd_val);
        cmp("osc_run", 1, osc_run);
        rd(rtck_pkg::ADDR_FLAGS);
        cmp("flags", rtck_pkg::FLAGS_RST, rd_val);
        m_trim = $urandom % 64;
        wr(rtck_pkg::ADDR_TRIM, 8'(m_trim));
        rd(rtck_pkg::ADDR_TRIM);
        cmp("trim", m_trim, rd_val & 8'h3F);
        wr(rtck_pkg::ADDR_TRIM, 8'h80);
        repeat (3) @(posedge clk);
        #1;
        cmp("osc_run", 0, osc_run);
        wr(rtck_pkg::ADDR_TRIM, 8'(m_trim));
        wr(rtck_pkg::ADDR_FLAGS, 8'h04);
        rd(rtck_pkg::ADDR_FLAGS);
        cmp("cal_locked", 0, rd_val[2]);
        wr(rtck_pkg::ADDR_FLAGS, 8'h02);
        wr(rtck_pkg::ADDR_FLAGS, 8'h06);
        wr(rtck_pkg::ADDR_FLAGS, 8'h04);
        rd(rtck_pkg::ADDR_FLAGS);
        cmp("cal_set", 1, rd_val[2]);
        wr(rtck_pkg::ADDR_IRQ_CTRL, 8'h0B);
        sq_chk(1);
        wr(rtck_pkg::ADDR_FLAGS, 8'h02);
        wr(rtck_pkg::ADDR_FLAGS, 8'h03);
        rd(rtck_pkg::ADDR_FLAGS);
        cmp("osc_fail_set", 1, rd_val[0]);
        rd(rtck_pkg::ADDR_FLAGS);
        cmp("osc_fail_read", 0, rd_val[0]);
        wr(rtck_pkg::ADDR_FLAGS, 8'h03);
        wr(rtck_pkg::ADDR_FLAGS, 8'h02);
        wr(rtck_pkg::ADDR_FLAGS, 8'h00);
        rd(rtck_pkg::ADDR_FLAGS);
        cmp("osc_fail_clear", 0, rd_val[0]);
        wr(rtck_pkg::ADDR_FLAGS, 8'h02);
        wr(rtck_pkg::ADDR_ALM_SEC, {1'b0, now_sec[6:0]});
        rd(rtck_pkg::ADDR_ALM_SEC);
        cmp("alarm_staged", {1'b0, now_sec[6:0]}, rd_val);
        wr(rtck_pkg::ADDR_FLAGS, 8'h00);
        wr(rtck_pkg::ADDR_ALM_SEC, 8'h80);
        rd(rtck_pkg::ADDR_ALM_SEC);
        cmp("alarm_locked", {1'b0, now_sec[6:0]}, rd_val);
        for (int s = 0; s < 4; s++) begin
            wr(rtck_pkg::ADDR_IRQ_CTRL, 8'(8 + s));
            sq_chk(s);
            cmp("square_oe", 1, int_oe);
        end
        @(posedge clk);
        on_backup_pin <= 1'b1;
        repeat (8) @(posedge clk);
        #1;
        cmp("backup_oe", 0, int_oe);
        @(posedge clk);
        on_backup_pin <= 1'b0;
        wr(rtck_pkg::ADDR_IRQ_CTRL, 8'h80);
        m_wd = 2;
        wr(rtck_pkg::ADDR_WD, 8'h82);
        wait_int(20000);
        if (!hit) begin
            n_mismatch++;
            $display("FAIL watchdog_irq expected 1 seen 0");
        end
        rd(rtck_pkg::ADDR_FLAGS);
        cmp("wd_flag", 1, rd_val[7]);
        repeat (2) @(posedge clk);
        #1;
        cmp("wd_irq", 0, int_oe);
        wr(rtck_pkg::ADDR_WD, 8'hC5);
        rd(rtck_pkg::ADDR_WD);
        cmp("wd_value", m_wd, rd_val);
        m_wd = 3;
        wr(rtck_pkg::ADDR_WD, 8'h83);
        rd(rtck_pkg::ADDR_WD);
        cmp("wd_value", m_wd, rd_val);
        repeat (5) begin
            repeat (4000) @(posedge clk);
            wr(rtck_pkg::ADDR_WD, 8'hC0);
        end
        rd(rtck_pkg::ADDR_FLAGS);
        cmp("wd_strobed", 0, rd_val[7]);
        m_wd = 0;
        wr(rtck_pkg::ADDR_WD, 8'h80);
        wait_int(14000);
        cmp("wd_disabled", 0, hit);
        wr(rtck_pkg::ADDR_TRIM, 8'h80);
        wr(rtck_pkg::ADDR_WD, 8'h81);
        wait_int(14000);
        cmp("wd_halted", 0, hit);
        cmp("time_reload", 0, time_reload);
        report_and_stop();
    end
endmodule

// [tb/rtck_core_asserts.sv]
// Purpose: Port level checks of the timekeeping core.
// Assumes: Register strobes last one cycle.
// Notes: Bound to every core instance.
module rtck_core_asserts (
    input wire logic clk,
    input wire logic rst,
    input wire logic osc_clk_pin,
    input wire logic on_backup_pin,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] now_sec,
    input wire logic [7:0] now_min,
    input wire logic [7:0] now_hour,
    input wire logic [7:0] now_date,
    input wire logic [7:0] reg_rdata,
    input wire logic osc_run,
    input wire logic time_reload,
    input wire logic int_level,
    input wire logic int_oe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    wire logic tw = reg_wr && reg_addr == rtck_pkg::ADDR_TRIM;
    wire logic tr = reg_rd && !reg_wr && reg_addr == rtck_pkg::ADDR_TRIM;
    wire logic ww = reg_wr && reg_addr == rtck_pkg::ADDR_WD;
    wire logic wr = reg_rd && !reg_wr && reg_addr == rtck_pkg::ADDR_WD;
    AST_RST_OUT: assert property ($past(rst) |-> !int_oe && !time_reload && reg_rdata == 8'h00)
        else $error("Outputs not quiet after reset.");
    AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("Read data not zero outside a read.");
    AST_OSC_WR: assert property (tw ##1 !tw |=> osc_run == !$past(reg_wdata[7], 2))
        else $error("Oscillator run does not follow the stop bit.");
    AST_TRIM_RD: assert property ((!tw) [*3] ##0 tr |=> reg_rdata[7] == !osc_run)
        else $error("Stop bit read back disagrees with oscillator run.");
    AST_TRIM_BACK: assert property (tw ##1 !reg_wr ##1 tr |=>
        reg_rdata[5:0] == $past(reg_wdata[5:0], 3)) else $error("Trim field read back wrong.");
    AST_WD_BACK: assert property (ww && !reg_wdata[6] ##1 !reg_wr ##1 wr |=>
        reg_rdata[5:0] == $past(reg_wdata[5:0], 3)) else $error("Timeout value not written.");
    AST_WD_HI: assert property (wr |=> reg_rdata[7:6] == 2'h0)
        else $error("Watchdog read shows control bits.");
    AST_BACKUP: assert property (on_backup_pin [*5] |-> !int_oe)
        else $error("Interrupt pin driven on backup power.");
    AST_RELOAD: assert property (time_reload |=> !time_reload)
        else $error("Time reload longer than one cycle.");
    cover property (wr ##1 reg_rdata[5:0] != 6'h00);
    cover property (int_oe && int_level);
    cover property (!osc_run);
endmodule
bind rtck_core rtck_core_asserts rtck_core_asserts_i (.clk, .rst, .osc_clk_pin, .on_backup_pin,
    .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .now_sec, .now_min, .now_hour, .now_date,
    .reg_rdata, .osc_run, .time_reload, .int_level, .int_oe);

// [tb/rtck_xtal_model.sv]
// Purpose: Crystal stand-in driving the oscillator pin of the core.
// Assumes: HALF clock cycles make half a crystal period.
// Notes: The pin stands still at low while the oscillator is disabled.
module rtck_xtal_model #(
    parameter int HALF = 3
) (
    input wire logic clk,
    input wire logic run,
    output logic osc
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    always @(posedge clk) begin
        if (!run) begin
            osc <= 1'b0;
            cnt <= 0;
        end else if (cnt == HALF - 1) begin
            osc <= !osc;
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule
